//--- core/cmd_status_regs.sv
// channel command/address and command/status register bank
`timescale 1ns/100ps
module cmd_status_regs
  import cmd_status_pkg::*;
(
  input  wire logic                    I_SYS_CLK,       // 250 MHz clock
  input  wire logic                    I_RSTN,          // sync reset, low
  input  wire cmd_status_pkg::bus_req_t I_BUS,          // register access
  input  wire cmd_status_pkg::pll_evt_t I_PLL_EVT,      // pll event pulses
  input  wire logic                    I_BIPHASE,       // biphase coding active
  input  wire logic                    I_CV_ACCEPT,     // code_violation_accept
  input  wire logic                    I_RCC_EN,        // rx_char_counter enabled
  input  wire logic                    I_CNT_PUSH,      // frame count arrives
  input  wire logic [cmd_status_pkg::CNT_W-1:0] I_CNT_DATA, // frame count
  input  wire logic                    I_CNT_POP,       // count consumed
  input  wire logic                    I_SLAVE_MONO,    // slaved monosync mode
  input  wire logic                    I_HDLC_LOOP,     // hdlc loop mode
  input  wire logic                    I_TX_ACTIVE,     // transmitter active
  input  wire logic                    I_LOOP_INSERTED, // channel in the loop
  input  wire logic                    I_TX_OWN_DATA,   // tx sending own data
  input  wire logic                    I_CHAN_LOAD_DONE,// load dma list ended
  input  wire logic [1:0]              I_TX_ACK_MODE,   // tx_ack_pin_mode
  input  wire logic [1:0]              I_RX_ACK_MODE,   // rx_ack_pin_mode
  input  wire logic                    I_TX_ACK_PIN_N,  // tx_ack_pin, async
  input  wire logic                    I_RX_ACK_PIN_N,  // rx_ack_pin, async
  output logic [cmd_status_pkg::REG_W-1:0] O_RDATA,     // read data
  output logic                         O_RVALID,        // read data valid
  output logic [cmd_status_pkg::PTR_W-1:0] O_TARGET,    // register reached
  output logic                         O_BYTE_ACC,      // byte-wide access
  output logic                         O_UPPER_BYTE,    // upper byte selected
  output logic                         O_IND_STB,       // indirect access pulse
  output logic                         O_CHAN_LOAD_RUN, // channel load continues
  output logic [1:0]                   O_PLL_EDGE,      // pll_edge_select
  output logic [2:0]                   O_TX_LAST_BITS,  // tx_last_bits
  output logic [cmd_status_pkg::CNT_W-1:0] O_CNT_HEAD   // count fifo head
);
  import cmd_status_pkg::*;

  // two-stage synchronisers for the ack pins
  logic [1:0] ack_s1_reg, ack_s1_next, ack_s2_reg, ack_s2_next;

  logic             cont_reg, cont_next, bw_reg, bw_next, ul_reg, ul_next;
  logic             lock_reg, lock_next, miss2_reg, miss2_next, miss1_reg, miss1_next;
  logic             on_loop_flag_reg, on_loop_flag_next, rvalid_reg, rvalid_next, ind_reg, ind_next;
  logic             byte_reg, byte_next, upper_reg, upper_next, run_reg, run_next;
  logic [PTR_W-1:0] ptr_reg, ptr_next, tgt_reg, tgt_next, eff_addr;
  logic [1:0]       edge_reg, edge_next;
  logic [2:0]       res_reg, res_next;
  logic [REG_W-1:0] rdata_reg, rdata_next, cs_view, ca_view;
  logic [CNT_W-1:0] fifo_head;
  logic             fifo_nonempty, fifo_ovf, purge, acc, ca_wr, cs_wr, ind_acc;

  // write-one-to-clear with set priority over the clear
  function automatic logic w1c(input logic cur, input logic set, input logic clr);
    return set | (cur & ~clr);
  endfunction : w1c

  // accesses to the command/address location go indirect while a pointer is held
  always_comb begin
    acc      = I_BUS.wr | I_BUS.rd;
    ind_acc  = acc && (I_BUS.addr == IDX_CMD_ADDR) && (ptr_reg != IDX_CMD_ADDR);
    eff_addr = ind_acc ? ptr_reg : I_BUS.addr;
    ca_wr    = I_BUS.wr && (eff_addr == IDX_CMD_ADDR);
    cs_wr    = I_BUS.wr && (eff_addr == IDX_CMD_STATUS);
    purge    = cs_wr && I_BUS.wdata[CS_PURGE_BIT];
  end

  always_comb begin
    cs_view = '0;
    cs_view[CS_OVFL_BIT]  = fifo_ovf;
    cs_view[CS_AVAIL_BIT] = fifo_nonempty;
    cs_view[CS_LOCK_BIT]  = lock_reg;
    cs_view[CS_MISS2_BIT] = miss2_reg;
    cs_view[CS_MISS1_BIT] = miss1_reg;
    cs_view[CS_EDGE_LSB +: 2] = edge_reg;
    cs_view[CS_ON_LOOP_FLAG_BIT] = on_loop_flag_reg;
    cs_view[CS_SEND_BIT]  = I_HDLC_LOOP & I_TX_OWN_DATA;
    cs_view[CS_RES_LSB +: 3] = res_reg;
    cs_view[CS_TX_ACK_PIN_BIT] = (I_TX_ACK_MODE == ACK_MODE_STATUS) & ~ack_s2_reg[1];
    cs_view[CS_RX_ACK_PIN_BIT] = (I_RX_ACK_MODE == ACK_MODE_STATUS) & ~ack_s2_reg[0];
    ca_view = '0;
    ca_view[CA_CONT_BIT] = cont_reg;   // write-only fields read as zero
  end

  always_comb begin
    cont_next  = cont_reg;
    bw_next    = bw_reg;
    ptr_next   = ptr_reg;
    ul_next    = ul_reg;
    edge_next  = edge_reg;
    res_next   = res_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    tgt_next   = tgt_reg;
    byte_next  = byte_reg;
    upper_next = upper_reg;
    ind_next   = 1'b0;
    if (acc) begin
      tgt_next   = eff_addr;
      byte_next  = I_BUS.bus16 ? bw_reg : 1'b1;
      upper_next = ul_reg;
    end
    if (ind_acc) begin
      ind_next = 1'b1;
      bw_next  = 1'b0;
      ptr_next = '0;
      ul_next  = 1'b0;
    end
    if (ca_wr) begin
      cont_next = I_BUS.wdata[CA_CONT_BIT];
      bw_next   = I_BUS.wdata[CA_BYTE_BIT];
      ptr_next  = I_BUS.wdata[CA_PTR_LSB +: PTR_W];
      ul_next   = I_BUS.wdata[CA_UPPER_BIT];
    end
    if (I_CHAN_LOAD_DONE) begin
      cont_next = 1'b0;
    end
    if (cs_wr) begin
      edge_next = I_BUS.wdata[CS_EDGE_LSB +: 2];
      res_next  = I_BUS.wdata[CS_RES_LSB +: 3];
    end
    if (I_BUS.rd) begin
      rvalid_next = 1'b1;
      if (eff_addr == IDX_CMD_STATUS) begin
        rdata_next = cs_view;
      end else if (eff_addr == IDX_CMD_ADDR) begin
        rdata_next = ca_view;
      end else begin
        rdata_next = '0;   // other registers live outside this bank
      end
      // byte reads land in the low lane
      if (I_BUS.bus16 ? bw_reg : 1'b1) begin
        rdata_next = ul_reg ? {8'h00, rdata_next[15:8]} : {8'h00, rdata_next[7:0]};
      end
    end
    run_next = cont_next;
  end

  // sticky status flags lock, miss2 and miss1; set wins over a same-cycle clear
  always_comb begin
    ack_s1_next = {I_TX_ACK_PIN_N, I_RX_ACK_PIN_N};
    ack_s2_next = ack_s1_reg;
    lock_next  = w1c(lock_reg, I_PLL_EVT.sync,
                     cs_wr & I_BUS.wdata[CS_LOCK_BIT]);
    miss2_next = w1c(miss2_reg, I_BIPHASE & I_PLL_EVT.miss2,
                     cs_wr & I_BUS.wdata[CS_MISS2_BIT]);
    miss1_next = w1c(miss1_reg, I_BIPHASE & ~I_CV_ACCEPT & I_PLL_EVT.miss1,
                     cs_wr & I_BUS.wdata[CS_MISS1_BIT]);
    if (I_SLAVE_MONO) begin
      on_loop_flag_next = on_loop_flag_reg | I_TX_ACTIVE;
    end else if (I_HDLC_LOOP) begin
      on_loop_flag_next = I_LOOP_INSERTED;
    end else begin
      on_loop_flag_next = 1'b0;
    end
  end

  always_ff @(posedge I_SYS_CLK) begin
    if (!I_RSTN) begin
      cont_reg   <= 1'b0;
      bw_reg     <= 1'b0;
      ptr_reg    <= '0;
      ul_reg     <= 1'b0;
      lock_reg   <= 1'b0;
      miss2_reg  <= 1'b0;
      miss1_reg  <= 1'b0;
      edge_reg   <= EDGE_RST;
      on_loop_flag_reg <= 1'b0;
      res_reg    <= RES_RST;
      rdata_reg  <= '0;
      rvalid_reg <= 1'b0;
      tgt_reg    <= '0;
      byte_reg   <= 1'b0;
      upper_reg  <= 1'b0;
      ind_reg    <= 1'b0;
      run_reg    <= 1'b0;
      ack_s1_reg <= PIN_IDLE;
      ack_s2_reg <= PIN_IDLE;
    end else begin
      cont_reg   <= cont_next;
      bw_reg     <= bw_next;
      ptr_reg    <= ptr_next;
      ul_reg     <= ul_next;
      lock_reg   <= lock_next;
      miss2_reg  <= miss2_next;
      miss1_reg  <= miss1_next;
      edge_reg   <= edge_next;
      on_loop_flag_reg <= on_loop_flag_next;
      res_reg    <= res_next;
      rdata_reg  <= rdata_next;
      rvalid_reg <= rvalid_next;
      tgt_reg    <= tgt_next;
      byte_reg   <= byte_next;
      upper_reg  <= upper_next;
      ind_reg    <= ind_next;
      run_reg    <= run_next;
      ack_s1_reg <= ack_s1_next;
      ack_s2_reg <= ack_s2_next;
    end
  end

  count_fifo #(
    .DEPTH (FIFO_DEPTH),
    .W     (CNT_W)
  ) u_count_fifo (
    .i_clk      (I_SYS_CLK),
    .i_rstn     (I_RSTN),
    .i_en       (I_RCC_EN),
    .i_push     (I_CNT_PUSH),
    .i_data     (I_CNT_DATA),
    .i_pop      (I_CNT_POP),
    .i_purge    (purge),
    .o_data     (fifo_head),
    .o_nonempty (fifo_nonempty),
    .o_overflow (fifo_ovf)
  );

  // head is registered inside the fifo; exposed as-is
  assign O_CNT_HEAD      = fifo_head;
  assign O_RDATA         = rdata_reg;
  assign O_RVALID        = rvalid_reg;
  assign O_TARGET        = tgt_reg;
  assign O_BYTE_ACC      = byte_reg;
  assign O_UPPER_BYTE    = upper_reg;
  assign O_IND_STB       = ind_reg;
  assign O_CHAN_LOAD_RUN = run_reg;
  assign O_PLL_EDGE      = edge_reg;
  assign O_TX_LAST_BITS  = res_reg;

  property p_ptr_selfclear;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (ind_acc && !ca_wr) |=> (ptr_reg == '0 && !bw_reg && !ul_reg);
  endproperty
  a_ptr_selfclear: assert property (p_ptr_selfclear)
    else $error("pointer fields not cleared after use");

  property p_ptr_target;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      ind_acc |=> (O_TARGET == $past(ptr_reg) && O_IND_STB);
  endproperty
  a_ptr_target: assert property (p_ptr_target)
    else $error("indirect access went to wrong register");

  property p_byte_mode;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (acc && I_BUS.bus16) |=> (O_BYTE_ACC == $past(bw_reg) && O_UPPER_BYTE == $past(ul_reg));
  endproperty
  a_byte_mode: assert property (p_byte_mode)
    else $error("byte width or lane wrong");

  property p_upper_lane;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (I_BUS.rd && I_BUS.bus16 && bw_reg && ul_reg && eff_addr == IDX_CMD_STATUS)
        |=> (O_RDATA[7:0] == $past(cs_view[15:8]) && O_RDATA[15:8] == 8'h00);
  endproperty
  a_upper_lane: assert property (p_upper_lane)
    else $error("upper byte not returned");

  property p_lock_set;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      I_PLL_EVT.sync |=> lock_reg;
  endproperty
  a_lock_set: assert property (p_lock_set)
    else $error("lock flag lost");

  property p_miss1_gate;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (I_PLL_EVT.miss1 && I_BIPHASE && !I_CV_ACCEPT) |=> miss1_reg;
  endproperty
  a_miss1_gate: assert property (p_miss1_gate)
    else $error("single miss not flagged");

  property p_w1c_zero_keeps;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (cs_wr && !I_BUS.wdata[CS_MISS2_BIT] && miss2_reg) |=> miss2_reg;
  endproperty
  a_w1c_zero_keeps: assert property (p_w1c_zero_keeps)
    else $error("write of zero cleared sticky bit");

  property p_edge_written;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      cs_wr |=> (O_PLL_EDGE == $past(I_BUS.wdata[9:8])
                 && O_TX_LAST_BITS == $past(I_BUS.wdata[4:2]));
  endproperty
  a_edge_written: assert property (p_edge_written)
    else $error("edge or last-bits field not stored");

  property p_on_loop_flag_slave;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (I_SLAVE_MONO && on_loop_flag_reg) |=> (on_loop_flag_reg || !$past(I_SLAVE_MONO));
  endproperty
  a_on_loop_flag_slave: assert property (p_on_loop_flag_slave)
    else $error("loop flag dropped in slaved monosync");

  property p_cont_run;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (ca_wr && !I_BUS.wdata[7]) |=> !O_CHAN_LOAD_RUN;
  endproperty
  a_cont_run: assert property (p_cont_run)
    else $error("channel load not ended");

  sequence s_cs_word_read;
    I_BUS.rd && I_BUS.bus16 && !bw_reg && (eff_addr == IDX_CMD_STATUS);
  endsequence

  property p_ack_status;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (s_cs_word_read ##0 (I_TX_ACK_MODE != ACK_MODE_STATUS)) |=> !O_RDATA[CS_TX_ACK_PIN_BIT];
  endproperty
  a_ack_status: assert property (p_ack_status)
    else $error("ack status shown outside status mode");

  property p_loop_send;
    @(posedge I_SYS_CLK) disable iff (!I_RSTN)
      (s_cs_word_read ##0 (I_HDLC_LOOP && I_TX_OWN_DATA)) |=> O_RDATA[CS_SEND_BIT];
  endproperty
  a_loop_send: assert property (p_loop_send)
    else $error("loop sending not shown");

endmodule : cmd_status_regs

//--- core/cmd_status_pkg.sv
// constants and carrier types for the channel command/status register bank
package cmd_status_pkg;

  localparam int           REG_W            = 16;
  localparam int           PTR_W            = 5;
  // register indices on the internal address (printed values)
  localparam logic [4:0]   IDX_CMD_ADDR     = 5'h00;
  localparam logic [4:0]   IDX_CMD_STATUS   = 5'h02;
  // cmd_addr_reg field positions
  localparam int           CA_CONT_BIT      = 7;
  localparam int           CA_BYTE_BIT      = 6;
  localparam int           CA_PTR_LSB       = 1;
  localparam int           CA_UPPER_BIT     = 0;
  // cmd_status_reg field positions
  localparam int           CS_OVFL_BIT      = 15;
  localparam int           CS_AVAIL_BIT     = 14;
  localparam int           CS_PURGE_BIT     = 13;
  localparam int           CS_LOCK_BIT      = 12;
  localparam int           CS_MISS2_BIT     = 11;
  localparam int           CS_MISS1_BIT     = 10;
  localparam int           CS_EDGE_LSB      = 8;
  localparam int           CS_ON_LOOP_FLAG_BIT    = 7;
  localparam int           CS_SEND_BIT      = 6;
  localparam int           CS_RES_LSB       = 2;
  localparam int           CS_TX_ACK_PIN_BIT     = 1;
  localparam int           CS_RX_ACK_PIN_BIT     = 0;
  // reset values and the ack-pin status mode code
  localparam logic [1:0]   EDGE_RST         = 2'h0;
  localparam logic [2:0]   RES_RST          = 3'h0;
  localparam logic [1:0]   ACK_MODE_STATUS  = 2'h0;
  // ack pins idle high, so synchronisers start there
  localparam logic [1:0]   PIN_IDLE         = 2'h3;
  // count fifo: five entries, each a finished frame count
  localparam int           FIFO_DEPTH       = 5;
  localparam int           CNT_W            = 16;

  typedef enum logic [1:0] {
    EDGE_BOTH    = 2'b00,
    EDGE_RISE    = 2'b01,
    EDGE_FALL    = 2'b10,
    EDGE_FREERUN = 2'b11
  } pll_edge_t;

  // bus request carrier
  typedef struct packed {
    logic             wr;     // write strobe
    logic             rd;     // read strobe
    logic [PTR_W-1:0] addr;   // direct register address
    logic [REG_W-1:0] wdata;  // write data
    logic             bus16;  // 16-bit bus configured
  } bus_req_t;

  // pll events from the receive clock recovery
  typedef struct packed {
    logic sync;   // pll achieved lock
    logic miss1;  // single missing transition
    logic miss2;  // two consecutive missing transitions
  } pll_evt_t;

endpackage : cmd_status_pkg

//--- core/count_fifo.sv
// receive character-count fifo with overflow and purge
`timescale 1ns/100ps
module count_fifo #(
  parameter int DEPTH = cmd_status_pkg::FIFO_DEPTH,
  parameter int W     = cmd_status_pkg::CNT_W
) (
  input  wire logic         i_clk,    // system clock
  input  wire logic         i_rstn,   // sync reset, low
  input  wire logic         i_en,     // counter enabled
  input  wire logic         i_push,   // frame count arrives
  input  wire logic [W-1:0] i_data,   // frame count
  input  wire logic         i_pop,    // entry consumed
  input  wire logic         i_purge,  // empty and clear flags
  output logic [W-1:0]      o_data,   // head entry
  output logic              o_nonempty, // at least one entry
  output logic              o_overflow  // push while full without a pop
);
  import cmd_status_pkg::*;
  localparam int AW = $clog2(DEPTH + 1);

  logic [W-1:0]  mem_reg  [DEPTH];
  logic [W-1:0]  mem_next [DEPTH];
  logic [AW-1:0] cnt_reg, cnt_next;
  logic          ovf_reg, ovf_next;
  logic          full, do_push, do_pop;

  always_comb begin
    full     = (cnt_reg == AW'(DEPTH));
    do_pop   = i_pop && (cnt_reg != '0);
    do_push  = i_en && i_push && (!full || do_pop);
    mem_next = mem_reg;
    cnt_next = cnt_reg;
    ovf_next = ovf_reg;
    if (do_pop) begin
      for (int k = 0; k < DEPTH - 1; k++) begin
        mem_next[k] = mem_reg[k+1];
      end
    end
    if (do_push) begin
      mem_next[do_pop ? cnt_reg - AW'(1) : cnt_reg] = i_data;
    end
    cnt_next = cnt_reg + AW'(do_push) - AW'(do_pop);
    if (i_en && i_push && full && !do_pop) begin
      ovf_next = 1'b1;
    end
    if (i_purge) begin
      cnt_next = '0;
      ovf_next = 1'b0;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      cnt_reg <= '0;
      ovf_reg <= 1'b0;
      for (int k = 0; k < DEPTH; k++) begin
        mem_reg[k] <= '0;
      end
    end else begin
      cnt_reg <= cnt_next;
      ovf_reg <= ovf_next;
      mem_reg <= mem_next;
    end
  end

  assign o_data     = mem_reg[0];
  assign o_nonempty = (cnt_reg != '0);
  assign o_overflow = ovf_reg;

  property p_nonempty_tracks;
    @(posedge i_clk) disable iff (!i_rstn)
      (do_push && !i_purge) |=> o_nonempty;
  endproperty
  a_nonempty_tracks: assert property (p_nonempty_tracks)
    else $error("fifo empty after push");

  property p_overflow_set;
    @(posedge i_clk) disable iff (!i_rstn)
      (i_en && i_push && full && !do_pop && !i_purge) |=> o_overflow;
  endproperty
  a_overflow_set: assert property (p_overflow_set)
    else $error("overflow not flagged");

  property p_purge_clears;
    @(posedge i_clk) disable iff (!i_rstn)
      i_purge |=> (!o_nonempty && !o_overflow);
  endproperty
  a_purge_clears: assert property (p_purge_clears)
    else $error("purge left fifo state");

endmodule : count_fifo

//--- bench/host_bus_model.sv
// host processor model driving the register bus
`timescale 1ns/100ps
module host_bus_model
  import cmd_status_pkg::*;
(
  input  wire logic                         i_clk,    // system clock
  input  wire logic                         i_rvalid, // read data valid
  input  wire logic [cmd_status_pkg::REG_W-1:0] i_rdata, // read data
  output cmd_status_pkg::bus_req_t          o_bus     // bus request
);
  initial begin
    o_bus       = '0;
    o_bus.bus16 = 1'b1;
  end

  task automatic access(input logic w, input logic [4:0] a, input logic [15:0] d,
                        output logic [15:0] q, output logic ok);
    o_bus.wr    = w;
    o_bus.rd    = ~w;
    o_bus.addr  = a;
    o_bus.wdata = d;
    @(posedge i_clk);
    #1;
    // released lines show the inverse so stale values never pass for data
    o_bus.wr    = 1'b0;
    o_bus.rd    = 1'b0;
    o_bus.addr  = ~a;
    o_bus.wdata = ~d;
    ok          = w;
    q           = '0;
    for (int n = 0; n < 4 && !ok; n++) begin
      if (i_rvalid === 1'b1) begin
        q  = i_rdata;
        ok = 1'b1;
      end else begin
        @(posedge i_clk);
        #1;
      end
    end
    // one idle edge keeps strobes from being set twice in one step
    @(posedge i_clk);
    #1;
  endtask : access

  task automatic set_bus16(input logic b);
    o_bus.bus16 = b;
  endtask : set_bus16
endmodule : host_bus_model

//--- bench/tb_cmd_status_regs.sv
// self-checking bench for the command/status register bank
`timescale 1ns/100ps
module tb_cmd_status_regs;
  import cmd_status_pkg::*;
  logic        clk = 0, rstn = 0, biphase = 0, cv = 0, rcc_en = 0, push = 0;
  logic        smono = 0, hloop = 0, tx_act = 0, ins = 0, own = 0, done = 0;
  logic        txp = 1, rxp = 1, rvalid, byte_acc, upper, load_run, pop = 0, ind_stb;
  logic [1:0]  txm = 0, rxm = 0, edge_o;
  logic [2:0]  last_bits;
  logic [4:0]  target;
  logic [15:0] rdata, q, head, cnt_data = 16'h0000;
  pll_evt_t    evt = '0;
  bus_req_t    bus;
  int          errors = 0, check_count = 0, ind_seen = 0;

  always #2 clk = ~clk;

  // the strobe stands one cycle, so it is counted at every edge
  always @(posedge clk) begin
    if (ind_stb === 1'b1) ind_seen++;
  end

  cmd_status_regs DUT (.I_SYS_CLK(clk), .I_RSTN(rstn), .I_BUS(bus), .I_PLL_EVT(evt),
    .I_BIPHASE(biphase), .I_CV_ACCEPT(cv), .I_RCC_EN(rcc_en), .I_CNT_PUSH(push),
    .I_CNT_DATA(cnt_data), .I_CNT_POP(pop), .I_SLAVE_MONO(smono), .I_HDLC_LOOP(hloop),
    .I_TX_ACTIVE(tx_act), .I_LOOP_INSERTED(ins), .I_TX_OWN_DATA(own),
    .I_CHAN_LOAD_DONE(done), .I_TX_ACK_MODE(txm), .I_RX_ACK_MODE(rxm),
    .I_TX_ACK_PIN_N(txp), .I_RX_ACK_PIN_N(rxp), .O_RDATA(rdata), .O_RVALID(rvalid),
    .O_TARGET(target), .O_BYTE_ACC(byte_acc), .O_UPPER_BYTE(upper), .O_IND_STB(ind_stb),
    .O_CHAN_LOAD_RUN(load_run), .O_PLL_EDGE(edge_o), .O_TX_LAST_BITS(last_bits),
    .O_CNT_HEAD(head));
  host_bus_model host (.i_clk(clk), .i_rvalid(rvalid), .i_rdata(rdata), .o_bus(bus));

  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick

  task automatic stop_test();
    if (errors == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : stop_test

  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    check_count++;
    if (g !== e) begin
      errors++;
      $display("MISMATCH %0t got %h exp %h", $time, g, e);
    end
  endtask : chk

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    logic ok;
    host.access(1'b1, a, d, q, ok);
  endtask : wr

  task automatic rd(input logic [4:0] a);
    logic ok;
    host.access(1'b0, a, 16'h0000, q, ok);
    if (!ok) begin
      errors++;
      stop_test();
    end
  endtask : rd

  task automatic t_ptr();
    wr(5'h02, 16'h0214);
    wr(5'h00, 16'h0045);
    rd(5'h00);
    chk(q, 16'h0002);
    chk({9'h000, target, byte_acc, upper}, 16'h000B);
    wr(5'h00, 16'h0044);
    rd(5'h00);
    chk(q, 16'h0014);
    wr(5'h00, 16'h0004);
    rd(5'h00);
    chk(q, 16'h0214);
    rd(5'h00);
    chk({11'h000, target}, 16'h0000);
    chk(q, 16'h0000);
    rd(5'h1F);
    chk(q, 16'h0000);
    chk(16'(ind_seen), 16'h0003);
  endtask : t_ptr

  task automatic t_cfg();
    for (int i = 0; i < 8; i++) begin
      wr(5'h02, {6'h00, i[1:0], 3'h0, i[2:0], 2'h0});
      chk({11'h000, edge_o, last_bits}, {11'h000, i[1:0], i[2:0]});
      rd(5'h02);
      chk(q, {6'h00, i[1:0], 3'h0, i[2:0], 2'h0});
    end
    // narrow bus: every access is a byte, in the lane that the upper-byte bit selects (low here)
    host.set_bus16(1'b0);
    rd(5'h02);
    chk(q, 16'h001C);
    chk({15'h0000, byte_acc}, 16'h0001);
    host.set_bus16(1'b1);
    wr(5'h02, 16'h0000);
  endtask : t_cfg

  task automatic t_flags();
    biphase = 1;
    evt = 3'b111;
    tick(1);
    evt = '0;
    rd(5'h02);
    chk(q, 16'h1C00);
    wr(5'h02, 16'h0000);
    rd(5'h02);
    chk(q, 16'h1C00);
    wr(5'h02, 16'h1000);
    rd(5'h02);
    chk(q, 16'h0C00);
    wr(5'h02, 16'h0C00);
    cv = 1;
    evt.miss1 = 1;
    tick(1);
    evt = '0;
    rd(5'h02);
    chk(q, 16'h0000);
    biphase = 0;
    cv = 0;
  endtask : t_flags

  task automatic t_fifo();
    rcc_en = 1;
    push = 1;
    for (int i = 1; i <= 5; i++) begin
      cnt_data = 16'(i);
      tick(1);
    end
    // push with a pop while full is no overflow
    pop = 1;
    tick(1);
    push = 0;
    pop = 0;
    rd(5'h02);
    chk(q, 16'h4000);
    chk(head, 16'h0002);
    push = 1;
    tick(1);
    push = 0;
    rd(5'h02);
    chk(q, 16'hC000);
    wr(5'h02, 16'h2000);
    rd(5'h02);
    chk(q, 16'h0000);
  endtask : t_fifo

  task automatic t_loop();
    smono = 1;
    tx_act = 1;
    tick(1);
    tx_act = 0;
    tick(2);
    rd(5'h02);
    chk(q, 16'h0080);
    smono = 0;
    tick(2);
    rd(5'h02);
    chk(q, 16'h0000);
    hloop = 1;
    ins = 1;
    own = 1;
    tick(2);
    rd(5'h02);
    chk(q, 16'h00C0);
    own = 0;
    tick(2);
    rd(5'h02);
    chk(q, 16'h0080);
    hloop = 0;
    ins = 0;
  endtask : t_loop

  task automatic t_ack();
    txp = 0;
    rxp = 0;
    tick(4);
    rd(5'h02);
    chk(q, 16'h0003);
    txm = 2'b01;
    tick(1);
    rd(5'h02);
    chk(q, 16'h0001);
    txm = 2'b00;
  endtask : t_ack

  task automatic t_load();
    wr(5'h00, 16'h0080);
    chk({15'h0000, load_run}, 16'h0001);
    rd(5'h00);
    chk(q, 16'h0080);
    wr(5'h00, 16'h0000);
    chk({15'h0000, load_run}, 16'h0000);
    wr(5'h00, 16'h0080);
    done = 1;
    tick(1);
    done = 0;
    tick(1);
    chk({15'h0000, load_run}, 16'h0000);
  endtask : t_load

  initial begin
    tick(6);
    rstn = 1;
    rd(5'h02);
    chk(q, 16'h0000);
    t_ptr();
    t_cfg();
    t_flags();
    t_fifo();
    t_loop();
    t_ack();
    t_load();
    stop_test();
  end
endmodule : tb_cmd_status_regs
